// >>> hdl/scr_pkg.sv
package scr_pkg;

    // ------------------------------------------------------------
    // Register port and map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BAUD = 4'h1;
    localparam logic [3:0] REG_RXBUF = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0001;
    localparam int ST_FULL = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_BUSY = 2;

    // ------------------------------------------------------------
    // Mode and clock source codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_UART7 = 2'h1;
    localparam logic [1:0] MODE_UART8 = 2'h2;
    localparam logic [1:0] MODE_UART9 = 2'h3;
    localparam logic [1:0] SRC_BAUD = 2'h0;
    localparam logic [1:0] SRC_SYS = 2'h1;
    localparam logic [1:0] SRC_TIMER = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_LAST = 4'hf;
    localparam logic [3:0] CNT_START = 4'h1;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;
    localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
    localparam logic [3:0] DIV_FULL = 4'h0;
    localparam logic [4:0] DIV_SIXTEEN = 5'h10;
    localparam logic [3:0] FRAC_N_MIN = 4'h2;
    localparam logic [3:0] FRAC_N_MAX = 4'hf;
    localparam int PRE_W = 8;

    // ------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] rsvd;
        logic rx_enable;
        logic ninth_enable;
        logic wakeup_filter;
        logic [1:0] uart_clock_source;
        logic shift_clock_edge;
        logic shift_clock_direction;
        logic [1:0] mode;
    } scr_ctrl_s;

    typedef struct packed {
        logic [4:0] rsvd;
        logic fraction_enable;
        logic [1:0] prescale_tap_select;
        logic [3:0] fraction_k_field;
        logic [3:0] integer_divisor_field;
    } scr_baud_s;

endpackage

// >>> hdl/scr_baud_gen.sv
`timescale 1ns/1ps
module scr_baud_gen (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Configuration
    input scr_pkg::scr_baud_s cfg,
    input wire logic uart_mode,
    // Output tick
    output logic tick_ff
);
    logic [scr_pkg::PRE_W-1:0] pre_ff;
    logic [4:0] div_cnt_ff;
    logic [3:0] acc_ff;
    logic ext_ff;
    logic tap_hit;
    logic frac_ok;
    logic [4:0] n_val;
    logic [4:0] last;
    logic [4:0] nxt_acc;

    always_comb begin
        unique case (cfg.prescale_tap_select)
            2'h0: tap_hit = &pre_ff[1:0];
            2'h1: tap_hit = &pre_ff[3:0];
            2'h2: tap_hit = &pre_ff[5:0];
            default: tap_hit = &pre_ff[7:0];
        endcase
    end

    // A zero divisor field stands for sixteen.
    assign n_val = (cfg.integer_divisor_field == scr_pkg::DIV_FULL) ? scr_pkg::DIV_SIXTEEN
                   : {1'b0, cfg.integer_divisor_field};
    assign frac_ok = cfg.fraction_enable && uart_mode
                     && cfg.integer_divisor_field >= scr_pkg::FRAC_N_MIN
                     && cfg.integer_divisor_field <= scr_pkg::FRAC_N_MAX
                     && cfg.fraction_k_field != 4'h0;
    assign nxt_acc = {1'b0, acc_ff} + (scr_pkg::DIV_SIXTEEN - {1'b0, cfg.fraction_k_field});
    assign last = n_val - 5'h01 + {4'h0, ext_ff};

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    // Stretching 16-K periods in sixteen by one tap, on the carries of a (16-K) accumulator,
    // gives the average N + (16-K)/16 without a fractional counter.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_cnt_ff <= '0;
            acc_ff <= '0;
            ext_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (tap_hit) begin
                if (div_cnt_ff >= last) begin
                    div_cnt_ff <= '0;
                    tick_ff <= 1'b1;
                    acc_ff <= frac_ok ? nxt_acc[3:0] : 4'h0;
                    ext_ff <= frac_ok && nxt_acc[4];
                end else begin
                    div_cnt_ff <= div_cnt_ff + 5'h01;
                end
            end
        end
    end

    property p_int_period;
        @(posedge CLK) disable iff (!ARST_N)
        (tick_ff && !frac_ok) |-> ($past(div_cnt_ff) >= $past(n_val) - 5'h01) && $past(tap_hit);
    endproperty
    a_int_period: assert property (p_int_period) else $error("baud tick early");

    property p_tap;
        @(posedge CLK) disable iff (!ARST_N)
        (cfg.prescale_tap_select == 2'h1 && tap_hit) |-> pre_ff[3:0] == 4'hf;
    endproperty
    a_tap: assert property (p_tap) else $error("prescale tap wrong");
endmodule

// >>> hdl/scr_os_counter.sv
`timescale 1ns/1ps
module scr_os_counter (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Control
    input wire logic en,
    input wire logic load,
    input wire logic [scr_pkg::CNT_W-1:0] load_val,
    // Status
    output logic [scr_pkg::CNT_W-1:0] cnt_ff,
    output logic wrap_ff
);
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (en) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wrap_ff <= 1'b0;
        end else begin
            wrap_ff <= en && !load && cnt_ff == scr_pkg::CNT_LAST;
        end
    end

    property p_wrap;
        @(posedge CLK) disable iff (!ARST_N)
        wrap_ff |-> $past(cnt_ff) == scr_pkg::CNT_LAST && cnt_ff == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("tick not on sixteenth count");
endmodule

// >>> hdl/scr_top.sv
// Function
// - Fraction enabled in UART mode divides tap clock by N plus (16-K)/16.
// - Fraction off ignores K and divides the selected tap by N, 1 to 16.
// - Fraction only applies for N of 2 to 15 and K of 1 to 15.
// - Two-bit tap select picks prescaler divide by 4, 16, 64 or 256.
// - External clock in UART mode gives a bit rate of that clock over 16.
// - External clock in synchronous mode shifts one bit per clock period.
// - Timer match may be the UART oversampling clock, never the sync clock.
// - Synchronous clock output is the baud generator output divided by 2.
// - Synchronous clock input is made by detecting the chosen pin edge.
// - UART clock source picks baud generator, system clock, timer or pin.
// - Four-bit receive counter spends 16 clocks per bit, samples 7th to 9th.
// - Each asynchronously received bit is the majority of its three samples.
// - A start bit is accepted when two of three samples are low.
// - Clock output mode samples the receive pin on the chosen generated edge.
// - Clock input mode samples the receive pin on the chosen external edge.
// - A full 7 or 8 bit word moves to the holding buffer and interrupts.
// - A word arriving while holding is unread flags overrun and is dropped.
// - Ninth bit holds parity in 8-bit mode or the top data bit in 9-bit.
// - Nine-bit mode with wakeup filter interrupts only when ninth bit is 1.
// - Four-bit transmit counter emits a bit tick every 16 oversampling clocks.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module scr_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [scr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [scr_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [scr_pkg::DATA_W-1:0] RDATA,
    // Serial pins
    input wire logic RXD,
    input wire logic SCLK_IN,
    output logic SCLK_OUT,
    output logic SCLK_OE_N,
    // Timer and events
    input wire logic TIMER_MATCH,
    output logic RX_INT,
    output logic TX_TICK
);
    typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_BITS, RX_STOP} scr_rx_e;

    scr_pkg::scr_ctrl_s ctrl_ff;
    scr_pkg::scr_baud_s baud_ff;
    scr_rx_e state_ff;
    logic [scr_pkg::DATA_W-1:0] rdata_ff;
    logic [8:0] shift_ff;
    logic [8:0] hold_ff;
    logic [8:0] nxt_shift;
    logic [3:0] bitcnt_ff;
    logic [1:0] samp_ff;
    logic full_ff;
    logic overrun_ff;
    logic rx_int_ff;
    logic sclk_ff;
    logic oe_n_ff;
    logic pin_q_ff;
    logic pin_rise;
    logic pin_fall;
    logic uart;
    logic sync_out;
    logic baud_tick;
    logic os_tick;
    logic sync_sample;
    logic [3:0] rx_cnt;
    logic [3:0] cur;
    logic vote;
    logic ninth;
    logic [3:0] nbits;
    logic decide;
    logic xfer;
    logic wake_ok;
    logic rd_buf;
    logic rd_stat;

    // ------------------------------------------------------------
    // Clock selection
    // ------------------------------------------------------------
    assign uart = ctrl_ff.mode != scr_pkg::MODE_SYNC;
    assign sync_out = !uart && !ctrl_ff.shift_clock_direction;
    assign pin_rise = SCLK_IN && !pin_q_ff;
    assign pin_fall = !SCLK_IN && pin_q_ff;

    scr_baud_gen u_baud (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .cfg(baud_ff),
        .uart_mode(uart),
        .tick_ff(baud_tick)
    );

    // The timer source is reachable only through the UART source field, so
    // synchronous mode can never be clocked by it.
    always_comb begin
        unique case (ctrl_ff.uart_clock_source)
            scr_pkg::SRC_BAUD: os_tick = baud_tick;
            scr_pkg::SRC_SYS: os_tick = 1'b1;
            scr_pkg::SRC_TIMER: os_tick = TIMER_MATCH;
            default: os_tick = pin_rise;
        endcase
    end

    // Generated shift clock edges are sampled in the cycle they are driven.
    assign sync_sample = ctrl_ff.rx_enable && !uart
                         && (ctrl_ff.shift_clock_direction
                             ? (ctrl_ff.shift_clock_edge ? pin_fall : pin_rise)
                             : baud_tick && sclk_ff == ctrl_ff.shift_clock_edge);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_q_ff <= 1'b1;
        end else begin
            pin_q_ff <= SCLK_IN;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sclk_ff <= 1'b1;
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= !sync_out;
            if (!sync_out || !ctrl_ff.rx_enable) begin
                sclk_ff <= 1'b1;
            end else if (baud_tick) begin
                sclk_ff <= !sclk_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit counters
    // ------------------------------------------------------------
    scr_os_counter u_rx_cnt (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .en(os_tick && state_ff != RX_IDLE),
        .load(os_tick && uart && ctrl_ff.rx_enable && state_ff == RX_IDLE && !RXD),
        .load_val(scr_pkg::CNT_START),
        .cnt_ff(rx_cnt),
        .wrap_ff()
    );

    scr_os_counter u_tx_cnt (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .en(os_tick && uart),
        .load(1'b0),
        .load_val(4'h0),
        .cnt_ff(),
        .wrap_ff(TX_TICK)
    );

    // ------------------------------------------------------------
    // Receive sequencing
    // ------------------------------------------------------------
    assign cur = rx_cnt + 4'h1;
    assign vote = (samp_ff[0] & samp_ff[1]) | (samp_ff[0] & RXD) | (samp_ff[1] & RXD);
    assign decide = os_tick && state_ff != RX_IDLE && cur == scr_pkg::SAMPLE_LAST;
    assign ninth = ctrl_ff.mode == scr_pkg::MODE_UART9
                   || (ctrl_ff.mode == scr_pkg::MODE_UART8 && ctrl_ff.ninth_enable);
    assign nbits = (ctrl_ff.mode == scr_pkg::MODE_UART7 && !ctrl_ff.ninth_enable) ? 4'h7
                   : (ninth ? 4'h9 : 4'h8);

    always_comb begin
        nxt_shift = shift_ff;
        xfer = 1'b0;
        if (sync_sample) begin
            nxt_shift[bitcnt_ff] = RXD;
            xfer = bitcnt_ff == scr_pkg::SYNC_LAST_BIT;
        end else if (decide && state_ff == RX_BITS) begin
            nxt_shift[bitcnt_ff] = vote;
            xfer = ninth && bitcnt_ff == nbits - 4'h1;
        end else if (decide && state_ff == RX_STOP) begin
            xfer = !ninth;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= RX_IDLE;
        end else if (!ctrl_ff.rx_enable || !uart) begin
            state_ff <= RX_IDLE;
        end else if (state_ff == RX_IDLE) begin
            if (os_tick && !RXD) begin
                state_ff <= RX_HUNT;
            end
        end else if (decide) begin
            unique case (state_ff)
                RX_HUNT: state_ff <= vote ? RX_IDLE : RX_BITS;
                RX_BITS: state_ff <= (bitcnt_ff == nbits - 4'h1) ? RX_STOP : RX_BITS;
                default: state_ff <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            samp_ff <= '0;
        end else if (os_tick && cur >= scr_pkg::SAMPLE_FIRST && cur < scr_pkg::SAMPLE_LAST) begin
            samp_ff <= {RXD, samp_ff[1]};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shift_ff <= '0;
            bitcnt_ff <= '0;
        end else if (xfer || (decide && state_ff == RX_HUNT)) begin
            shift_ff <= '0;
            bitcnt_ff <= '0;
        end else if (sync_sample || (decide && state_ff == RX_BITS)) begin
            shift_ff <= nxt_shift;
            bitcnt_ff <= bitcnt_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Holding buffer
    // ------------------------------------------------------------
    assign rd_buf = RD && ADDR == scr_pkg::REG_RXBUF;
    assign rd_stat = RD && ADDR == scr_pkg::REG_STATUS;
    assign wake_ok = !(ctrl_ff.mode == scr_pkg::MODE_UART9 && ctrl_ff.wakeup_filter)
                     || nxt_shift[8];

    // A read in the same cycle as a transfer frees the buffer in time.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_ff <= '0;
            full_ff <= 1'b0;
            rx_int_ff <= 1'b0;
        end else begin
            rx_int_ff <= 1'b0;
            if (xfer && !(full_ff && !rd_buf)) begin
                hold_ff <= nxt_shift;
                full_ff <= wake_ok;
                rx_int_ff <= wake_ok;
            end else if (rd_buf) begin
                full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            overrun_ff <= 1'b0;
        end else if (xfer && full_ff && !rd_buf) begin
            overrun_ff <= 1'b1;
        end else if (rd_stat) begin
            overrun_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_ff <= scr_pkg::CTRL_RST;
            baud_ff <= scr_pkg::BAUD_RST;
        end else if (WR && ADDR == scr_pkg::REG_CTRL) begin
            ctrl_ff <= {7'h00, WDATA[8:0]};
        end else if (WR && ADDR == scr_pkg::REG_BAUD) begin
            baud_ff <= {5'h00, WDATA[10:0]};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= '0;
        end else if (RD) begin
            unique case (ADDR)
                scr_pkg::REG_CTRL: rdata_ff <= ctrl_ff;
                scr_pkg::REG_BAUD: rdata_ff <= baud_ff;
                scr_pkg::REG_RXBUF: rdata_ff <= {7'h00, hold_ff};
                scr_pkg::REG_STATUS: rdata_ff <= {13'h0000, state_ff != RX_IDLE,
                                                  overrun_ff, full_ff};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign RDATA = rdata_ff;
    assign SCLK_OUT = sclk_ff;
    assign SCLK_OE_N = oe_n_ff;
    assign RX_INT = rx_int_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_overrun_keep;
        @(posedge CLK) disable iff (!ARST_N)
        (xfer && full_ff && !rd_buf) |=> overrun_ff && $stable(hold_ff) && !rx_int_ff;
    endproperty
    a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost buffer");

    property p_load_int;
        @(posedge CLK) disable iff (!ARST_N)
        (xfer && !full_ff && wake_ok) |=> rx_int_ff && full_ff && hold_ff == $past(nxt_shift);
    endproperty
    a_load_int: assert property (p_load_int) else $error("word not moved");

    property p_wakeup;
        @(posedge CLK) disable iff (!ARST_N)
        (rx_int_ff && ctrl_ff.mode == scr_pkg::MODE_UART9 && ctrl_ff.wakeup_filter) |-> hold_ff[8];
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup filter leak");

    property p_start;
        @(posedge CLK) disable iff (!ARST_N)
        (decide && state_ff == RX_HUNT && ctrl_ff.rx_enable && uart)
            |=> (state_ff == RX_BITS) == ($past(vote) == 1'b0);
    endproperty
    a_start: assert property (p_start) else $error("start vote ignored");

    property p_clk_div;
        @(posedge CLK) disable iff (!ARST_N)
        (sync_out && ctrl_ff.rx_enable && $past(sync_out) && $changed(sclk_ff))
            |-> $past(baud_tick);
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("shift clock moved off tick");

    property p_align;
        @(posedge CLK) disable iff (!ARST_N)
        (state_ff == RX_IDLE && os_tick && !RXD && uart && ctrl_ff.rx_enable)
            |=> rx_cnt == scr_pkg::CNT_START;
    endproperty
    a_align: assert property (p_align) else $error("counter not aligned");
endmodule

// >>> dv/scr_peer.sv
`timescale 1ns/1ps
module scr_peer (
    // Clock and link pins
    input wire logic clk,
    input wire logic sclk_out,
    output logic rxd,
    output logic sclk_in
);
    int pin_half = 0;
    int pc = 0;

    initial begin
        rxd = 1'b1;
        sclk_in = 1'b1;
    end

    // --------------------
    // Free serial clock
    // --------------------
    always @(posedge clk) begin
        pc <= pc + 1;
        if (pin_half != 0 && pc % pin_half == 0) begin
            sclk_in <= ~sclk_in;
        end
    end

    task automatic idle();
        pin_half = 0;
        sclk_in <= 1'b1;
    endtask

    // --------------------
    // Frames
    // --------------------
    // A one-cycle spike sits mid-bit, so one lone sample can not decide a bit.
    task automatic send(input logic [8:0] w, input int n);
        logic b;
        for (int i = -1; i <= n; i++) begin
            b = (i < 0) ? 1'b0 : (i == n) ? 1'b1 : w[i];
            rxd <= b;
            repeat (8) @(posedge clk);
            rxd <= ~b;
            @(posedge clk);
            rxd <= b;
            repeat (7) @(posedge clk);
        end
    endtask

    task automatic blip();
        rxd <= 1'b0;
        @(posedge clk);
        rxd <= 1'b1;
    endtask

    // Data moves four cycles away from either clock edge.
    task automatic sync_in(input logic [7:0] w);
        for (int i = 0; i < 8; i++) begin
            rxd <= w[i];
            repeat (4) @(posedge clk);
            sclk_in <= 1'b0;
            repeat (8) @(posedge clk);
            sclk_in <= 1'b1;
            repeat (4) @(posedge clk);
        end
        rxd <= ~rxd;
    endtask

    task automatic sync_out(input logic [7:0] w);
        for (int i = 0; i < 8; i++) begin
            @(negedge sclk_out);
            @(posedge clk);
            rxd <= w[i];
        end
        @(posedge sclk_out);
        repeat (2) @(posedge clk);
        rxd <= ~rxd;
    endtask
endmodule

// >>> dv/test_serial_clock_and_receive_path.sv
`timescale 1ns/1ps
module test_serial_clock_and_receive_path;
    logic clk, rx_int, tx_tick, rxd, sclk_in, sclk_out, sclk_oe_n;
    logic arst_n = 1'b0, wr = 1'b0, rd = 1'b0, tmr = 1'b0;
    logic [scr_pkg::ADDR_W-1:0] addr = '0;
    logic [scr_pkg::DATA_W-1:0] wdata = '0, rdata;
    int bad_count = 0, compares = 0, ints = 0, cyc = 0, gap;
    // Rows: control, baud, cycles between transmit ticks.
    int tbl[36] = '{16'h0012, 16'h0001, 16, 16'h0002, 16'h0001, 64, 2, 16'h0103, 768,
        2, 16'h0000, 1024, 2, 16'h0201, 1024, 2, 16'h0301, 4096, 2, 16'h0482, 160,
        2, 16'h0481, 64, 2, 16'h00f3, 192, 16'h0022, 1, 80, 16'h0032, 1, 64,
        2, 16'h048f, 992};

    // --------------------
    // Design and far side
    // --------------------
    scr_top i_scr_top (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RXD(rxd), .SCLK_IN(sclk_in),
        .SCLK_OUT(sclk_out), .SCLK_OE_N(sclk_oe_n), .TIMER_MATCH(tmr),
        .RX_INT(rx_int), .TX_TICK(tx_tick));
    scr_peer i_scr_peer (.clk(clk), .sclk_out(sclk_out), .rxd(rxd), .sclk_in(sclk_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        tmr <= (cyc % 5 == 0);
        if (rx_int === 1'b1) begin
            ints <= ints + 1;
        end
    end

    // --------------------
    // Bus and check tasks
    // --------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        compares++;
        if (got != exp) begin
            bad_count++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask

    task automatic tick_gap(output int n);
        n = 0;
        while (tx_tick !== 1'b1 && n < 9000) begin
            @(posedge clk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (tx_tick !== 1'b1 && n < 9000);
    endtask

    // Bit count n: 7 to 9 asynchronous, 1 clock input, 0 clock output.
    task automatic rx(input logic [15:0] c, input logic [8:0] w, input int n, input int di);
        int n0;
        n0 = ints;
        fork
            wr_reg(scr_pkg::REG_CTRL, c);
            if (n == 0) i_scr_peer.sync_out(w[7:0]);
        join
        if (n > 1) i_scr_peer.send(w, n);
        if (n == 1) i_scr_peer.sync_in(w[7:0]);
        repeat (4) @(posedge clk);
        chk_n(ints - n0, di);
        $display("case %h done at %0t", c, $time);
    endtask

    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // --------------------
    // Sequence
    // --------------------
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_chk(scr_pkg::REG_CTRL, scr_pkg::CTRL_RST);
        rd_chk(scr_pkg::REG_BAUD, scr_pkg::BAUD_RST);
        wr_reg(4'h5, 16'hffff);
        rd_chk(4'h5, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 36; i += 3) begin
            if (i == 30) i_scr_peer.pin_half = 2;
            wr_reg(scr_pkg::REG_BAUD, 16'(tbl[i+1]));
            wr_reg(scr_pkg::REG_CTRL, 16'(tbl[i]));
            tick_gap(gap);
            tick_gap(gap);
            chk_n(gap, tbl[i+2]);
        end
        chk({15'h0, sclk_oe_n}, 16'h0001);
        i_scr_peer.idle();
        $display("tick test done");
        wr_reg(scr_pkg::REG_CTRL, 16'h0112);
        i_scr_peer.blip();
        repeat (40) @(posedge clk);
        rd_chk(scr_pkg::REG_STATUS, 16'h0000);
        $display("false start test done");
        rx(16'h0112, 9'h0a5, 8, 1);
        rd_chk(scr_pkg::REG_RXBUF, 16'h00a5);
        rx(16'h0111, 9'h055, 7, 1);
        rd_chk(scr_pkg::REG_RXBUF, 16'h0055);
        rx(16'h0192, 9'h13c, 9, 1);
        rx(16'h0192, 9'h05a, 9, 0);
        rd_chk(scr_pkg::REG_STATUS, 16'h0003);
        rd_chk(scr_pkg::REG_RXBUF, 16'h013c);
        rd_chk(scr_pkg::REG_STATUS, 16'h0000);
        rx(16'h0153, 9'h0ff, 9, 0);
        rx(16'h0153, 9'h1c3, 9, 1);
        rd_chk(scr_pkg::REG_RXBUF, 16'h01c3);
        rx(16'h0104, 9'h096, 1, 1);
        rd_chk(scr_pkg::REG_RXBUF, 16'h0096);
        rx(16'h010c, 9'h069, 1, 1);
        rd_chk(scr_pkg::REG_RXBUF, 16'h0069);
        wr_reg(scr_pkg::REG_BAUD, 16'h0002);
        rx(16'h0100, 9'h0b4, 0, 1);
        chk({15'h0, sclk_oe_n}, 16'h0000);
        rd_chk(scr_pkg::REG_RXBUF, 16'h00b4);
        wr_reg(scr_pkg::REG_CTRL, 16'h0000);
        final_report();
    end

    // About twice the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("BAD %0t watchdog ran out", $time);
        final_report();
    end
endmodule
